// *** core/dswl_top.sv ***
// serial word loader and synthesis core
// Operation
// - load toggle moves word into core
// - word: 32 freq, 3 control, 5 phase
// - 32-bit accumulator, 14-bit table, 10-bit DAC
// - tuning clamped to 30 MHz ceiling
// - load after any bit count changes output
`timescale 1ns/1ps
`default_nettype none
module dswl_top #(
   parameter int ACC_BITS = 32
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic SDATA,
   input wire logic WCLK,
   input wire logic LOAD,
   output logic [9:0] DAC_OUT,
   output logic [39:0] ACTIVE_WORD,
   output logic [5:0] BIT_COUNT
);
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   dswl_pkg::dswl_pins_t s1_ff, s2_ff, s3_ff;
   dswl_pkg::dswl_pins_t pin_in;
   logic wclk_rise, load_edge;

   assign pin_in = '{sdata: SDATA, wclk: WCLK, load: LOAD};

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= pin_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // last level on which stages two and three agreed
   logic wclk_ok_ff, load_ok_ff;

   // a change counts once stages two and three agree
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         wclk_ok_ff <= 1'b0;
         load_ok_ff <= 1'b0;
      end else begin
         if (s2_ff.wclk == s3_ff.wclk) begin
            wclk_ok_ff <= s3_ff.wclk;
         end
         if (s2_ff.load == s3_ff.load) begin
            load_ok_ff <= s3_ff.load;
         end
      end
   end

   assign wclk_rise = s2_ff.wclk & s3_ff.wclk & ~wclk_ok_ff;
   // load acts on either edge: the host toggles it
   assign load_edge = (s2_ff.load ~^ s3_ff.load) & (s3_ff.load ^ load_ok_ff);

   // ------------------------------------------------------------
   // input shift register
   // ------------------------------------------------------------
   logic [39:0] shift_ff;
   logic [5:0] cnt_ff;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         shift_ff <= dswl_pkg::WORD_RST;
      end else if (wclk_rise) begin
         shift_ff <= {s3_ff.sdata, shift_ff[39:1]};
      end
   end

   // bit count saturates; reset by load for status only
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         cnt_ff <= dswl_pkg::BIT_CNT_RST;
      end else if (load_edge) begin
         cnt_ff <= dswl_pkg::BIT_CNT_RST;
      end else if (wclk_rise && cnt_ff != 6'(dswl_pkg::WORD_BITS)) begin
         cnt_ff <= cnt_ff + 6'h01;
      end
   end
   assign BIT_COUNT = cnt_ff;

   // ------------------------------------------------------------
   // active word
   // ------------------------------------------------------------
   dswl_pkg::dswl_word_t active_ff;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         active_ff <= dswl_pkg::WORD_RST;
      end else if (load_edge) begin
         active_ff <= shift_ff;
      end
   end
   assign ACTIVE_WORD = active_ff;

   // ------------------------------------------------------------
   // synthesis core
   // ------------------------------------------------------------
   logic [ACC_BITS-1:0] acc_ff;
   logic [31:0] ftw;
   logic [13:0] lut_addr;
   logic [13:0] phase_off;

   assign ftw = (active_ff.freq > dswl_pkg::FTW_MAX) ?
      dswl_pkg::FTW_MAX : active_ff.freq;

   // phase bits step in 11.25 degree units; control bits unused here
   assign phase_off = {active_ff.phase, 9'h000};

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         acc_ff <= '0;
      end else begin
         acc_ff <= acc_ff + ACC_BITS'(ftw);
      end
   end

   assign lut_addr = acc_ff[ACC_BITS-1 -: 14] + phase_off;

   dswl_sine_rom #(
      .AW(dswl_pkg::LUT_ADDR_BITS),
      .DW(dswl_pkg::DAC_BITS)
   ) u_rom (
      .clk(CLK),
      .addr(lut_addr),
      .data(DAC_OUT)
   );
endmodule // dswl_top
`default_nettype wire

// *** core/dswl_pkg.sv ***
// shared constants and types for the serial word loader
package dswl_pkg;
   localparam int WORD_BITS = 40;
   localparam int FREQ_BITS = 32;
   localparam int CTRL_BITS = 3;
   localparam int PHASE_BITS = 5;
   localparam int FREQ_LSB = 0;
   localparam int CTRL_LSB = 32;
   localparam int PHASE_LSB = 35;
   localparam int LUT_ADDR_BITS = 14;
   localparam int DAC_BITS = 10;
   localparam int REF_CLK_MHZ = 100;
   localparam int MAX_OUT_MHZ = 30;
   // largest tuning word giving 30 MHz out of a 100 MHz reference
   localparam logic [31:0] FTW_MAX = 32'(64'(MAX_OUT_MHZ) * 64'h1_0000_0000
      / 64'(REF_CLK_MHZ));
   localparam logic [5:0] BIT_CNT_RST = 6'h00;
   localparam logic [39:0] WORD_RST = 40'h00_0000_0000;

   typedef struct packed {
      logic [PHASE_BITS-1:0] phase;
      logic [CTRL_BITS-1:0] ctrl;
      logic [FREQ_BITS-1:0] freq;
   } dswl_word_t;

   typedef struct packed {
      logic sdata;
      logic wclk;
      logic load;
   } dswl_pins_t;
endpackage

// *** core/dswl_sine_rom.sv ***
// registered sine lookup table
`timescale 1ns/1ps
`default_nettype none
module dswl_sine_rom #(
   parameter int AW = 14,
   parameter int DW = 10
) (
   input wire logic clk,
   input wire logic [AW-1:0] addr,
   output logic [DW-1:0] data
);
   localparam int N = 1 << AW;
   logic [DW-1:0] rom [N];

   // table built at elaboration, offset binary around mid-scale
   initial begin
      for (int i = 0; i < N; i++) begin
         rom[i] = DW'($rtoi(((1 << (DW-1)) - 0.5) *
            (1.0 + $sin(2.0 * 3.14159265358979 * i / N))));
      end
   end

   always_ff @(posedge clk) begin
      data <= rom[addr];
   end
endmodule // dswl_sine_rom
`default_nettype wire

// *** test/dswl_props.sv ***
// loader checker
`timescale 1ns/1ps
`default_nettype none
module dswl_props (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic WCLK,
   input wire logic LOAD,
   input wire logic [9:0] DAC_OUT,
   input wire logic [39:0] ACTIVE_WORD,
   input wire logic [5:0] BIT_COUNT
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   count_cap_a: assert property (BIT_COUNT <= 6'h28)
      else $error("count above forty");
   count_step_a: assert property ($changed(BIT_COUNT) |->
      BIT_COUNT == $past(BIT_COUNT) + 6'h01 || BIT_COUNT == 6'h00)
      else $error("count jumped");
   shift_seen_a: assert property ($rose(WCLK) |->
      ##[2:5] $changed(BIT_COUNT) || BIT_COUNT == 6'h28)
      else $error("bit not taken");
   word_cause_a: assert property ($changed(ACTIVE_WORD) |->
      $past(LOAD, 2) != $past(LOAD, 6))
      else $error("word moved without load");
   load_clear_a: assert property ($changed(LOAD) |->
      ##[2:5] BIT_COUNT == 6'h00)
      else $error("load not taken");
   // slow tunings excluded: table steps too rarely
   dac_run_a: assert property (ACTIVE_WORD[31:26] != 6'h00 |->
      ##[1:4] $changed(DAC_OUT))
      else $error("sine output stuck");
endmodule // dswl_props
bind dswl_top dswl_props dswl_props_inst (.CLK, .RST_N, .WCLK, .LOAD,
   .DAC_OUT, .ACTIVE_WORD, .BIT_COUNT);
`default_nettype wire

// *** test/dswl_host.sv ***
// host model driving the three loader pins
`timescale 1ns/1ps
`default_nettype none
module dswl_host (
   input wire logic CLK,
   output logic SDATA = 1'b0,
   output logic WCLK = 1'b0,
   output logic LOAD = 1'b0
);
   // lsb first, data ahead of clock
   task automatic shift(input logic [39:0] w, input int n);
      // 16 cycles a bit: 64 ns write clock period
      for (int i = 0; i < n; i++) begin
         SDATA <= w[i];
         WCLK <= 1'b0;
         repeat (8) @(posedge CLK);
         WCLK <= 1'b1;
         repeat (8) @(posedge CLK);
      end
      // hold over: inverse, never the stale bit
      WCLK <= 1'b0;
      SDATA <= ~w[n-1];
      @(posedge CLK);
   endtask
   // toggle once the bits are in
   task automatic load();
      repeat (8) @(posedge CLK);
      LOAD <= ~LOAD;
      repeat (8) @(posedge CLK);
   endtask
endmodule // dswl_host
`default_nettype wire

// *** test/dswl_top_bench.sv ***
// bench for the serial word loader
`timescale 1ns/1ps
`default_nettype none
module dswl_top_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sd, wc, ld;
   logic [9:0] dac;
   logic [39:0] aw;
   logic [5:0] cnt;
   int errors = 0, cmp_count = 0, cycles = 0;
   always #2 clk = ~clk;
   dswl_top dswl_top_inst (.CLK(clk), .RST_N(rst_n), .SDATA(sd),
      .WCLK(wc), .LOAD(ld), .DAC_OUT(dac), .ACTIVE_WORD(aw),
      .BIT_COUNT(cnt));
   dswl_host dswl_host_inst (.CLK(clk), .SDATA(sd), .WCLK(wc), .LOAD(ld));
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: %h vs %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 10000) begin
         errors++;
         test_done();
      end
   end
   task automatic t_full(input logic [39:0] w);
      dswl_host_inst.shift(w, 40);
      chk({34'h0, cnt}, 40'h28);
      dswl_host_inst.load();
      chk(aw, w);
      chk({34'h0, cnt}, 40'h00);
   endtask
   // tuning kept in range, though the clamp never reaches ACTIVE_WORD, which the field check reads
   task automatic t_part(input logic [39:0] p, input logic [7:0] w);
      logic [39:0] e;
      e = p;
      for (int i = 0; i < 8; i++) e = {w[i], e[39:1]};
      dswl_host_inst.shift({32'h0, w}, 8);
      chk({34'h0, cnt}, 40'h08);
      dswl_host_inst.load();
      chk(aw, e);
   endtask
   // over-range tuning must run like the ceiling; restart aligns phase
   task automatic t_clamp();
      logic [9:0] ref_s [16];
      for (int k = 0; k < 2; k++) begin
         rst_n <= 1'b0;
         repeat (4) @(posedge clk);
         chk({30'h0, dac}, {30'h0, 10'h1FF});
         rst_n <= 1'b1;
         @(posedge clk);
         dswl_host_inst.shift({8'h00, k ? 32'hFFFF_FFFF : dswl_pkg::FTW_MAX},
            40);
         dswl_host_inst.load();
         for (int j = 0; j < 16; j++) begin
            @(negedge clk);
            if (k == 0) ref_s[j] = dac;
            else chk({30'h0, dac}, {30'h0, ref_s[j]});
         end
         // second toggle leaves the load pin low for the next reset
         dswl_host_inst.load();
      end
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_full({5'h01, 3'h3, 32'h1234_5678});
      t_part({5'h01, 3'h3, 32'h1234_5678}, 8'hC3);
      t_clamp();
      t_full({5'h1F, 3'h7, dswl_pkg::FTW_MAX});
      test_done();
   end
endmodule // dswl_top_bench
`default_nettype wire
